/* itp_pwm_encoder.v */
// two-channel temperature pwm encoder with status slot and relay driver
//
// Function
// - frame is 2048 pwm ticks, 102.4 ms nominal, frames follow back to back.
// - both outputs high for the first eighth of every frame.
// - data slot spans 1/8 to 5/8 of frame; high fraction encodes value.
// - each channel modulates a 10-bit value inside the data slot.
// - normal duty runs linearly from 12.5 % to 62.5 %.
// - status slot duties: underflow 68.75 %, overflow 75 %, fatal 81.25 %.
// - ambient out of range puts the ambient flag on both outputs.
// - stored calibration checked by ecc; only uncorrectable errors flag fatal.
// - relay switches at a 50 degC threshold with 5 degC hysteresis.
// - inverting turns relay off above threshold; non-inverting turns it on.
// - relay comparator is digital, 12-bit, inverting unless reprogrammed.
// - object out of range clamps object output to 12.5 % or 62.5 %.
`timescale 1ns/1ps
`default_nettype none
`include "itp_defs.vh"

module itp_pwm_encoder #(
  parameter TICK_CYCLES = `ITP_PWM_TICK_NS / `ITP_CLK_PERIOD_NS,
  parameter TICK_W = `ITP_TICK_W,
  parameter TEMP_W = `ITP_TEMP_W,
  parameter PWM_BITS = `ITP_PWM_BITS
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // linearised temperature codes from the conversion datapath
  input wire [TEMP_W-1:0] object_temp,
  input wire [TEMP_W-1:0] ambient_temp,
  // calibrated-range indications from the conversion datapath
  input wire object_below_range,
  input wire object_above_range,
  input wire ambient_below_range,
  input wire ambient_above_range,
  // stored relay threshold word, ecc protected
  input wire [`ITP_ECC_CW_W-1:0] cal_code_word,
  // factory polarity setting, low selects inverting
  input wire relay_noninvert,
  // pwm outputs
  output wire object_temp_out,
  output wire ambient_temp_out,
  // open-drain relay driver, enable high while sinking
  output reg relay_drive_out_o,
  output reg relay_drive_out_oe,
  // condition flags sent in the current frame
  output reg ambient_underflow_flag,
  output reg ambient_overflow_flag,
  output reg fatal_storage_error_flag,
  // one-cycle pulse at each frame start except the first after reset
  output reg frame_start_pulse
);

  localparam NCH = 2;
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  // divider end count, cut to the counter width on purpose
  localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_I[TICK_W-1:0];

  // tick divider and frame position
  reg [TICK_W-1:0] tick_cnt_q;
  reg [`ITP_FRAME_W-1:0] frame_cnt_q;
  wire tick;
  wire frame_end;

  // ecc results and relay comparator state
  wire [`ITP_ECC_DATA_W-1:0] relay_threshold;
  wire ecc_fatal;
  wire relay_above;

  // per-channel packing for the generate loop
  wire [NCH*TEMP_W-1:0] temp_bus;
  wire [NCH-1:0] obj_low;
  wire [NCH-1:0] obj_high;
  wire [NCH-1:0] pwm_bits;

  assign temp_bus = {ambient_temp, object_temp};
  // range clamping on a single channel only concerns the object output
  assign obj_low = {1'b0, object_below_range};
  assign obj_high = {1'b0, object_above_range};

  assign tick = (tick_cnt_q == TICK_LAST);
  assign frame_end = tick && (frame_cnt_q == `ITP_FRAME_LAST);

  // 50 us pwm clock derived from the core clock
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= {TICK_W{1'b0}};
    end else if (tick) begin
      tick_cnt_q <= {TICK_W{1'b0}};
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // frame counter wraps after 2048 ticks with no gap between frames
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_cnt_q <= {`ITP_FRAME_W{1'b0}};
    end else if (tick) begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  // frame start marker for anyone timing the outputs
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_start_pulse <= 1'b0;
    end else begin
      frame_start_pulse <= frame_end;
    end
  end

  // calibration store check
  itp_ecc_check #(
    .DATA_W(`ITP_ECC_DATA_W),
    .CW_W(`ITP_ECC_CW_W)
  ) u_ecc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .code_word(cal_code_word),
    .data_q(relay_threshold),
    .corrected_q(),
    .fatal_q(ecc_fatal)
  );

  // relay comparator on the object temperature at full 12-bit width
  itp_relay_cmp #(
    .TEMP_W(TEMP_W),
    .HYST(`ITP_RELAY_HYST_5C)
  ) u_relay (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .temp(object_temp),
    .threshold(relay_threshold),
    .above_q(relay_above)
  );

  // polarity: inverting releases the relay above threshold
  // a broken threshold store cannot be trusted, so the relay is released
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      relay_drive_out_o <= 1'b0;
      relay_drive_out_oe <= 1'b0;
    end else begin
      relay_drive_out_o <= 1'b0;
      if (ecc_fatal) begin
        relay_drive_out_oe <= 1'b0;
      end else if (relay_noninvert) begin
        relay_drive_out_oe <= relay_above;
      end else begin
        relay_drive_out_oe <= ~relay_above;
      end
    end
  end

  // flags are sampled at the frame boundary so they match the frame sent
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ambient_underflow_flag <= 1'b0;
      ambient_overflow_flag <= 1'b0;
      fatal_storage_error_flag <= 1'b0;
    end else if (frame_end) begin
      fatal_storage_error_flag <= ecc_fatal;
      ambient_underflow_flag <= !ecc_fatal && ambient_below_range;
      ambient_overflow_flag <= !ecc_fatal && !ambient_below_range && ambient_above_range;
    end
  end

  // one modulator per output channel
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      wire [TEMP_W-1:0] temp_ch;
      wire [PWM_BITS-1:0] value;
      reg [`ITP_FRAME_W-1:0] end_d;
      reg [`ITP_FRAME_W-1:0] end_q;
      reg pwm_q;

      assign temp_ch = temp_bus[ch*TEMP_W +: TEMP_W];
      // one flop per channel keeps a single driver per output bit
      assign pwm_bits[ch] = pwm_q;
      // keep the top 10 bits of the code for the modulator
      assign value = temp_ch[TEMP_W-1 -: PWM_BITS];

      // high-time end point, highest priority condition first
      always @* begin
        if (ecc_fatal) begin
          end_d = `ITP_FATAL_END;
        end else if (ambient_below_range) begin
          end_d = `ITP_UFLOW_END;
        end else if (ambient_above_range) begin
          end_d = `ITP_OFLOW_END;
        end else if (obj_low[ch]) begin
          end_d = `ITP_LEAD_END;
        end else if (obj_high[ch]) begin
          end_d = `ITP_DATA_END;
        end else begin
          // 12.5 % plus value/2048, linear across the data slot
          end_d = `ITP_LEAD_END + {1'b0, value};
        end
      end

      // end point only changes at a frame boundary, never mid-frame
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          end_q <= `ITP_LEAD_END;
        end else if (frame_end) begin
          end_q <= end_d;
        end
      end

      // high from frame start until the end point, then low until the wrap
      // end_q never drops below the leading buffer, so the buffer is always high
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pwm_q <= 1'b0;
        end else begin
          pwm_q <= (frame_cnt_q < end_q);
        end
      end
    end
  endgenerate

  assign object_temp_out = pwm_bits[0];
  assign ambient_temp_out = pwm_bits[1];

endmodule
`default_nettype wire

/* itp_defs.vh */
// constants shared by the temperature pwm encoder files
`ifndef ITP_DEFS_VH
`define ITP_DEFS_VH

// core clock period and pwm tick period, both in ns
`define ITP_CLK_PERIOD_NS 4
`define ITP_PWM_TICK_NS 50000

// tick counter width, wide enough for the default tick count
`define ITP_TICK_W 14

// frame timing in pwm ticks, counter is 11 bits wide
`define ITP_FRAME_W 11
`define ITP_FRAME_TICKS 2048
`define ITP_FRAME_LAST 11'h7FF

// high-time end points inside a frame (ticks from frame start)
// leading buffer ends at 1/8 of the frame (12.5 %)
`define ITP_LEAD_END 11'h100
// data slot ends at 5/8 of the frame (62.5 %)
`define ITP_DATA_END 11'h500
// status slot ends: ambient underflow 68.75 %, overflow 75 %, fatal 81.25 %
`define ITP_UFLOW_END 11'h580
`define ITP_OFLOW_END 11'h600
`define ITP_FATAL_END 11'h680

// modulator resolution and width of the incoming temperature codes
`define ITP_PWM_BITS 10
`define ITP_TEMP_W 12

// stored calibration word: 12 data bits, 5 hamming bits, 1 overall parity
`define ITP_ECC_DATA_W 12
`define ITP_ECC_CW_W 18
`define ITP_ECC_LAST_POS 17
`define ITP_ECC_SYN_W 5

// relay hysteresis: 5 degC on a 140 degC span over 4096 codes
`define ITP_RELAY_HYST_5C 12'h092

`endif

/* itp_ecc_check.v */
// single-correct double-detect checker for the stored calibration word
`timescale 1ns/1ps
`default_nettype none
`include "itp_defs.vh"

module itp_ecc_check #(
  parameter DATA_W = `ITP_ECC_DATA_W,
  parameter CW_W = `ITP_ECC_CW_W
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // stored word, bit 0 overall parity, bits 1..17 hamming positions
  input wire [CW_W-1:0] code_word,
  // corrected data and status
  output reg [DATA_W-1:0] data_q,
  output reg corrected_q,
  output reg fatal_q
);

  reg [`ITP_ECC_SYN_W-1:0] syn;
  reg [CW_W-1:0] fixed;
  reg [DATA_W-1:0] data_d;
  reg par_odd;
  reg uncorr;
  integer i;
  integer k;

  // syndrome, single-bit repair and data extraction
  always @* begin
    syn = {`ITP_ECC_SYN_W{1'b0}};
    fixed = code_word;
    data_d = {DATA_W{1'b0}};
    k = 0;
    par_odd = ^code_word;
    for (i = 1; i <= `ITP_ECC_LAST_POS; i = i + 1) begin
      if (code_word[i]) begin
        syn = syn ^ i[`ITP_ECC_SYN_W-1:0];
      end
    end
    // even parity with a nonzero syndrome means two flips: beyond repair
    uncorr = (!par_odd && syn != {`ITP_ECC_SYN_W{1'b0}}) ||
             (par_odd && syn > `ITP_ECC_LAST_POS);
    if (par_odd && !uncorr) begin
      fixed[syn] = ~fixed[syn];
    end
    for (i = 1; i <= `ITP_ECC_LAST_POS; i = i + 1) begin
      if ((i & (i - 1)) != 0) begin
        data_d[k] = fixed[i];
        k = k + 1;
      end
    end
  end

  // fatal is sticky: a broken store does not heal itself
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_q <= {DATA_W{1'b0}};
      corrected_q <= 1'b0;
      fatal_q <= 1'b0;
    end else begin
      data_q <= data_d;
      corrected_q <= par_odd && !uncorr;
      fatal_q <= fatal_q | uncorr;
    end
  end

endmodule
`default_nettype wire

/* itp_relay_cmp.v */
// hysteretic digital comparator for the relay driver
`timescale 1ns/1ps
`default_nettype none
`include "itp_defs.vh"

module itp_relay_cmp #(
  parameter TEMP_W = `ITP_TEMP_W,
  parameter [TEMP_W-1:0] HYST = `ITP_RELAY_HYST_5C
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // compared value and switching threshold
  input wire [TEMP_W-1:0] temp,
  input wire [TEMP_W-1:0] threshold,
  // comparator state: temperature above threshold
  output reg above_q
);

  wire [TEMP_W-1:0] low_point;

  // release point saturates at zero for very low thresholds
  assign low_point = (threshold > HYST) ? (threshold - HYST) : {TEMP_W{1'b0}};

  // set above the threshold, clear only once below threshold minus hysteresis
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      above_q <= 1'b0;
    end else if (temp > threshold) begin
      above_q <= 1'b1;
    end else if (temp < low_point) begin
      above_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* itp_pwm_encoder_sva.sv */
// assertion checker for the temperature pwm encoder
`timescale 1ns/1ps
`default_nettype none
module itp_pwm_encoder_sva #(
  parameter int TICK_CYCLES = 12500
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // observed pins
  input wire logic relay_noninvert,
  input wire logic object_temp_out,
  input wire logic ambient_temp_out,
  input wire logic relay_drive_out_o,
  input wire logic relay_drive_out_oe,
  input wire logic ambient_underflow_flag,
  input wire logic ambient_overflow_flag,
  input wire logic fatal_storage_error_flag,
  input wire logic frame_start_pulse
);
  logic [31:0] cnt_q;
  logic primed_q;
  // position inside the frame, zero on the start pulse
  wire [31:0] pos = frame_start_pulse ? 32'h0 : cnt_q;
  wire [2:0] flags = {ambient_underflow_flag, ambient_overflow_flag, fatal_storage_error_flag};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // first frame after reset has no start pulse, so the frame timing checks wait for one
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
      primed_q <= 1'b0;
    end else begin
      cnt_q <= frame_start_pulse ? 32'h1 : cnt_q + 32'h1;
      if (frame_start_pulse) primed_q <= 1'b1;
    end
  end
  property p_period; primed_q && frame_start_pulse |-> cnt_q == 2048 * TICK_CYCLES; endproperty
  a_period: assert property (p_period) else $error("frame period wrong");
  // outputs rise one cycle after the start pulse and stay high end*TICK_CYCLES cycles
  property p_lead; primed_q && pos >= 1 && pos <= 256 * TICK_CYCLES |-> object_temp_out && ambient_temp_out;
  endproperty
  a_lead: assert property (p_lead) else $error("leading buffer not high");
  property p_tail; primed_q && pos > 1664 * TICK_CYCLES |-> !object_temp_out && !ambient_temp_out; endproperty
  a_tail: assert property (p_tail) else $error("output high past status slot");
  property p_rise; primed_q && ($rose(object_temp_out) || $rose(ambient_temp_out)) |-> $past(frame_start_pulse);
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge inside frame");
  property p_flags_one; $onehot0(flags); endproperty
  a_flags_one: assert property (p_flags_one) else $error("several status flags");
  property p_flags_hold; !frame_start_pulse |-> $stable(flags); endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved mid frame");
  property p_fatal_rel; fatal_storage_error_flag |-> !relay_drive_out_oe; endproperty
  a_fatal_rel: assert property (p_fatal_rel) else $error("relay on with fatal error");
  property p_od_low; !relay_drive_out_o; endproperty
  a_od_low: assert property (p_od_low) else $error("relay data not low");
  property p_polarity; $changed(relay_noninvert) && !fatal_storage_error_flag |=> $changed(relay_drive_out_oe); endproperty
  a_polarity: assert property (p_polarity) else $error("polarity flip ignored");
  c_under: cover property (frame_start_pulse && ambient_underflow_flag);
  c_over: cover property (frame_start_pulse && ambient_overflow_flag);
  c_fatal: cover property (frame_start_pulse && fatal_storage_error_flag);
endmodule
bind itp_pwm_encoder itp_pwm_encoder_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.core_clk(core_clk),
  .sys_rst(sys_rst), .relay_noninvert(relay_noninvert), .object_temp_out(object_temp_out),
  .ambient_temp_out(ambient_temp_out), .relay_drive_out_o(relay_drive_out_o),
  .relay_drive_out_oe(relay_drive_out_oe), .ambient_underflow_flag(ambient_underflow_flag),
  .ambient_overflow_flag(ambient_overflow_flag), .fatal_storage_error_flag(fatal_storage_error_flag),
  .frame_start_pulse(frame_start_pulse));
`default_nettype wire

/* itp_pwm_rx.sv */
// timer-capture receiver measuring one pwm line
`timescale 1ns/1ps
`default_nettype none
module itp_pwm_rx (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // measured line
  input wire logic pwm,
  // last complete frame
  output logic [15:0] high_q,
  output logic [15:0] period_q,
  output logic status_q
);
  logic pwm_q;
  logic [15:0] cnt_q;
  logic [15:0] hi_q;
  // capture on each rising edge, as a timer input would
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_q <= 1'b0;
      cnt_q <= 16'h0;
      hi_q <= 16'h0;
      high_q <= 16'h0;
      period_q <= 16'h0;
      status_q <= 1'b0;
    end else begin
      pwm_q <= pwm;
      if (pwm && !pwm_q) begin
        period_q <= cnt_q;
        high_q <= hi_q;
        status_q <= (hi_q * 8) > (cnt_q * 5);
        cnt_q <= 16'h1;
        hi_q <= 16'h1;
      end else begin
        cnt_q <= cnt_q + 16'h1;
        hi_q <= hi_q + {15'h0, pwm};
      end
    end
  end
endmodule
`default_nettype wire

/* itp_tb.sv */
// self-checking bench for the temperature pwm encoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tb;
  localparam int TC = 2;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] object_temp = 12'h000;
  logic [11:0] ambient_temp = 12'h000;
  logic [3:0] rng = 4'h0;
  logic [17:0] cal_code_word = 18'h30003; // 0x800 threshold, clean
  logic relay_noninvert = 1'b0;
  wire object_temp_out, ambient_temp_out, drv_o, drv_oe, f_u, f_o, f_f, sp;
  wire [15:0] ho, po, ha, pa;
  wire so, sa;
  int fail_count = 0;
  int n_tests = 0;
  // pulled-up open-drain relay line
  wire relay_line = drv_oe ? drv_o : 1'b1;
  always #2 core_clk = ~core_clk;
  itp_pwm_encoder #(.TICK_CYCLES(TC)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .object_temp(object_temp), .ambient_temp(ambient_temp), .object_below_range(rng[3]),
    .object_above_range(rng[2]), .ambient_below_range(rng[1]), .ambient_above_range(rng[0]),
    .cal_code_word(cal_code_word), .relay_noninvert(relay_noninvert), .object_temp_out(object_temp_out),
    .ambient_temp_out(ambient_temp_out), .relay_drive_out_o(drv_o), .relay_drive_out_oe(drv_oe),
    .ambient_underflow_flag(f_u), .ambient_overflow_flag(f_o), .fatal_storage_error_flag(f_f),
    .frame_start_pulse(sp));
  itp_pwm_rx rx_o (.core_clk(core_clk), .sys_rst(sys_rst), .pwm(object_temp_out),
    .high_q(ho), .period_q(po), .status_q(so));
  itp_pwm_rx rx_a (.core_clk(core_clk), .sys_rst(sys_rst), .pwm(ambient_temp_out),
    .high_q(ha), .period_q(pa), .status_q(sa));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_pulse();
    @(negedge core_clk);
    while (sp !== 1'b1) @(negedge core_clk);
  endtask
  // apply inputs, let n frames start, then judge the last whole frame
  task automatic frame(input logic [11:0] ot, at, input logic [3:0] r, input int n,
      input logic [15:0] eo, ea, input logic [2:0] ef);
    logic [2:0] fl;
    object_temp = ot;
    ambient_temp = at;
    rng = r;
    repeat (n - 1) wait_pulse();
    fl = {f_u, f_o, f_f};
    wait_pulse();
    repeat (3) @(negedge core_clk);
    `CHK("obj_high", eo * TC, ho)
    `CHK("amb_high", ea * TC, ha)
    `CHK("period", 2048 * TC, po)
    `CHK("amb_period", 2048 * TC, pa)
    `CHK("flags", ef, fl)
    `CHK("obj_status", ef != 3'b000, so)
    `CHK("amb_status", ef != 3'b000, sa)
  endtask
  task automatic t_normal();
    frame(12'h7FF, 12'h000, 4'h0, 2, 16'd767, 16'd256, 3'b000);
    frame(12'hFFF, 12'hFFC, 4'h0, 2, 16'd1279, 16'd1279, 3'b000);
  endtask
  task automatic t_obj_clamp();
    frame(12'h400, 12'h400, 4'h8, 2, 16'd256, 16'd512, 3'b000);
    frame(12'h400, 12'h400, 4'h4, 2, 16'd1280, 16'd512, 3'b000);
  endtask
  task automatic t_ambient();
    frame(12'h400, 12'h400, 4'h2, 2, 16'd1408, 16'd1408, 3'b100);
    frame(12'h400, 12'h400, 4'h1, 2, 16'd1536, 16'd1536, 3'b010);
    frame(12'h400, 12'h400, 4'h7, 2, 16'd1408, 16'd1408, 3'b100);
    frame(12'h400, 12'h400, 4'h0, 2, 16'd512, 16'd512, 3'b000);
  endtask
  // single flipped bit must still give the 0x800 threshold
  task automatic t_relay();
    cal_code_word = 18'h30023;
    repeat (4) @(negedge core_clk);
    `CHK("relay_idle", 1'b0, relay_line)
    object_temp = 12'h800;
    repeat (4) @(negedge core_clk);
    `CHK("relay_eq", 1'b0, relay_line)
    object_temp = 12'h801;
    repeat (4) @(negedge core_clk);
    `CHK("relay_above", 1'b1, relay_line)
    object_temp = 12'h76E;
    repeat (4) @(negedge core_clk);
    `CHK("relay_hyst", 1'b1, relay_line)
    relay_noninvert = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("relay_noninv", 1'b0, relay_line)
    object_temp = 12'h76D;
    repeat (4) @(negedge core_clk);
    `CHK("relay_off", 1'b1, relay_line)
    relay_noninvert = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("relay_inv", 1'b0, relay_line)
  endtask
  // double error cannot be corrected: sticky fatal on both lines
  task automatic t_fatal();
    cal_code_word = 18'h30063;
    frame(12'h400, 12'h400, 4'h1, 3, 16'd1664, 16'd1664, 3'b001);
    `CHK("relay_fatal", 1'b1, relay_line)
  endtask
  // watchdog: about twenty-three frames, three more than the run needs
  initial begin
    #380000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    wait_pulse();
    t_normal();
    t_obj_clamp();
    t_ambient();
    t_relay();
    t_fatal();
    stop_test();
  end
endmodule
`default_nettype wire
